// >>> test/prm_mapper_chk.sv
// Port checker for the range mapper: target answers, limits, busy, position.
// Assumes binding onto prm_mapper; one clock, async active-low reset.
module prm_mapper_chk
    import prm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic signed [31:0] enc_pos,
    input wire logic tgt_wr,
    input wire logic signed [31:0] tgt_val,
    input wire logic busy,
    input wire logic param_err,
    input wire logic tgt_ok,
    input wire logic tgt_err,
    input wire logic dir_rev,
    input wire prm_pkg::prm_fac_t numerator,
    input wire prm_pkg::prm_fac_t denominator,
    input wire logic signed [31:0] ref_value,
    input wire logic signed [31:0] act_pos,
    input wire logic signed [31:0] map_end,
    input wire logic signed [31:0] lo_limit,
    input wire logic signed [31:0] hi_limit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Target inside the usable span; only meaningful while idle
    wire tgt_in = (tgt_val >= lo_limit) && (tgt_val <= hi_limit);
    // Standard scaling only, so margins are plain step counts
    wire std_scl = (numerator == denominator);
    a_tgt_once: assert property ((tgt_ok || tgt_err) |=> !(tgt_ok || tgt_err))
        else $error("target answer longer than one cycle");
    a_tgt_bad: assert property (tgt_wr && !busy && !tgt_in |=> tgt_err && !tgt_ok)
        else $error("target in margin not refused");
    a_tgt_good: assert property (tgt_wr && !busy && tgt_in |=> tgt_ok && !tgt_err)
        else $error("target in range not accepted");
    a_tgt_cause: assert property ((tgt_ok || tgt_err) |-> $past(tgt_wr))
        else $error("target answer without request");
    a_lim_outer: assert property (!busy && std_scl |->
        hi_limit <= map_end - 1200 && lo_limit >= map_end - 101200)
        else $error("limits outside margins");
    a_map_relim: assert property ($changed(map_end) && std_scl |->
        lo_limit == map_end - 101200 && hi_limit == map_end - 1200)
        else $error("limits not recomputed with map end");
    a_fac_range: assert property (numerator >= 14'h1 && numerator <= 14'h2710
        && denominator >= 14'h1 && denominator <= 14'h2710)
        else $error("scaling factor out of range");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:600] !busy)
        else $error("busy stuck");
    a_act_track: assert property ($stable(enc_pos) && $stable(ref_value)
        && $stable(dir_rev) |-> act_pos == (dir_rev ? -enc_pos : enc_pos) + ref_value)
        else $error("actual position not tracking");
    a_err_hold: assert property ($rose(param_err) |-> $stable(map_end)
        && $stable(lo_limit) && $stable(hi_limit))
        else $error("refused write changed range");
    c_tgt_err: cover property (tgt_err);
    c_map_new: cover property ($changed(map_end));
    c_par_err: cover property ($rose(param_err));
endmodule

bind prm_mapper prm_mapper_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .enc_pos(enc_pos),
    .tgt_wr(tgt_wr), .tgt_val(tgt_val), .busy(busy), .param_err(param_err), .tgt_ok(tgt_ok),
    .tgt_err(tgt_err), .dir_rev(dir_rev), .numerator(numerator), .denominator(denominator),
    .ref_value(ref_value), .act_pos(act_pos), .map_end(map_end), .lo_limit(lo_limit),
    .hi_limit(hi_limit));

// >>> test/prm_master.sv
// Fieldbus master stand-in: one parameter write at a time into the mapper.
// Assumes the bench holds go, op and val until ack is seen.
module prm_master
    import prm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go, // Request from bench
    input wire logic [3:0] op, // 0 dir 1 num 2 den 3 ref 4 act 5 map 6 lo 7 hi 8 tgt
    input wire logic signed [31:0] val,
    input wire logic busy,
    output logic [8:0] strobe_r, // One-hot write strobes
    output logic signed [31:0] wval_r, // Shared write data
    output logic ack_r // Write issued
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only issue while idle, writes in bench order; a busy mapper would drop all but target writes
    wire take = go && !busy && !ack_r;
    // Strobe and ack
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_r <= 9'h000;
            ack_r <= 1'b0;
        end else begin
            strobe_r <= take ? (9'h001 << op) : 9'h000;
            ack_r <= take;
        end
    end
    // Data valid with its strobe only; inverted after, so stale capture shows
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wval_r <= 32'h0000_0000;
        end else begin
            wval_r <= take ? val : ~wval_r;
        end
    end
endmodule

// >>> test/tb_top.sv
// Bench for the range mapper: writes via the master model, checks queued notes.
// Assumes prm_mapper, prm_master and the bound checker are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import prm_pkg::*;
    typedef struct {string name; logic [31:0] exp;} prm_note_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [3:0] op = 4'h0;
    logic signed [31:0] val = 32'h0000_0000;
    logic signed [31:0] enc_pos = 51200; // Centre of default range
    logic motor_pwr_ok = 1'b1;
    logic chk = 1'b0; // Asks the watcher to compare state notes
    logic busy, param_err, tgt_ok, tgt_err, dir_rev, ack;
    logic [8:0] strobe;
    logic signed [31:0] wval, ref_value, act_pos, map_end, lo_limit, hi_limit;
    prm_fac_t numerator, denominator;
    prm_note_s notes[$];
    int miscompares = 0;
    int total_checks = 0;
    int seed = 32'h4F63;
    logic signed [31:0] rnd;
    always #10 sys_clk = ~sys_clk;
    prm_master u_master (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .op(op), .val(val),
        .busy(busy), .strobe_r(strobe), .wval_r(wval), .ack_r(ack));
    prm_mapper DUT (.sys_clk(sys_clk), .rst_n(rst_n), .enc_pos(enc_pos),
        .motor_pwr_ok(motor_pwr_ok), .dir_wr(strobe[0]), .dir_val(wval[0]),
        .num_wr(strobe[1]), .num_val(wval[13:0]), .den_wr(strobe[2]), .den_val(wval[13:0]),
        .ref_wr(strobe[3]), .ref_val(wval), .act_wr(strobe[4]), .act_val(wval),
        .map_wr(strobe[5]), .map_val(wval), .lo_wr(strobe[6]), .lo_val(wval),
        .hi_wr(strobe[7]), .hi_val(wval), .tgt_wr(strobe[8]), .tgt_val(wval), .busy(busy),
        .param_err(param_err), .tgt_ok(tgt_ok), .tgt_err(tgt_err), .dir_rev(dir_rev),
        .numerator(numerator), .denominator(denominator), .ref_value(ref_value),
        .act_pos(act_pos), .map_end(map_end), .lo_limit(lo_limit), .hi_limit(hi_limit));
    // Compare one value, count it, report a difference
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", name, $signed(exp), $signed(seen));
        end
    endtask
    task automatic note(input string name, input logic [31:0] exp);
        notes.push_back('{name, exp});
    endtask
    // Output picked by note name; target answer is the fallback
    function automatic logic [31:0] seen_of(input string name);
        case (name)
            "map_end": return map_end;
            "lo_limit": return lo_limit;
            "hi_limit": return hi_limit;
            "param_err": return 32'(param_err);
            "numerator": return 32'(numerator);
            "denominator": return 32'(denominator);
            "ref_value": return ref_value;
            "act_pos": return act_pos;
            "dir_rev": return 32'(dir_rev);
            default: return {30'h0, tgt_ok, tgt_err};
        endcase
    endfunction
    // One write through the master, then wait for the mapper to go idle
    task automatic wr(input logic [3:0] o, input logic signed [31:0] v);
        int n;
        n = 0;
        @(posedge sys_clk);
        go <= 1'b1;
        op <= o;
        val <= v;
        while (ack !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        go <= 1'b0;
        repeat (3) @(posedge sys_clk);
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 1000) miscompares++;
    endtask
    // Have the watcher compare everything noted so far
    task automatic post();
        chk <= 1'b1;
        @(posedge sys_clk);
        chk <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic st(input logic e, input int m, input int l, input int h);
        note("param_err", 32'(e));
        note("map_end", m);
        note("lo_limit", l);
        note("hi_limit", h);
        post();
    endtask
    task automatic tgt(input int v, input logic ok);
        note("tgt", ok ? 32'h2 : 32'h1);
        wr(4'h8, v);
    endtask
    // Watcher on the falling edge, where outputs are settled
    always @(negedge sys_clk) begin
        prm_note_s n;
        if ((tgt_ok === 1'b1 || tgt_err === 1'b1) && notes.size() > 0) begin
            n = notes.pop_front();
            check(n.name, n.exp, seen_of(n.name));
        end
        while (chk && notes.size() > 0) begin
            n = notes.pop_front();
            check(n.name, n.exp, seen_of(n.name));
        end
    end
    task automatic close_out();
        if (notes.size() != 0) miscompares++;
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        note("act_pos", 51200);
        note("numerator", 400);
        note("denominator", 400);
        st(1'b0, 102400, 1200, 101200);
        tgt(1199, 1'b0);
        tgt(1200, 1'b1);
        tgt(101200, 1'b1);
        tgt(101201, 1'b0);
        rnd = 1200 + ($random(seed) & 32'h0000_FFFF);
        tgt(rnd, 1'b1);
        wr(4'h6, 1300);
        wr(4'h5, 152401);
        st(1'b1, 102400, 1300, 101200);
        wr(4'h5, 152400);
        st(1'b0, 152400, 51200, 151200);
        wr(4'h5, 52399);
        st(1'b1, 152400, 51200, 151200);
        wr(4'h5, 52400);
        st(1'b0, 52400, -48800, 51200);
        wr(4'h5, 102400);
        st(1'b0, 102400, 1200, 101200);
        wr(4'h6, 1199);
        st(1'b1, 102400, 1200, 101200);
        wr(4'h6, 2000);
        wr(4'h7, 101201);
        wr(4'h7, 100000);
        st(1'b1, 102400, 2000, 100000);
        tgt(1999, 1'b0);
        tgt(100001, 1'b0);
        tgt(100000, 1'b1);
        wr(4'h1, 0);
        wr(4'h1, 10001);
        note("numerator", 400);
        post();
        wr(4'h2, 1);
        wr(4'h1, 3);
        note("numerator", 3);
        note("denominator", 1);
        wr(4'h5, 84934);
        note("param_err", 1);
        post();
        wr(4'h5, 84933);
        st(1'b0, 84933, 51200, 84533);
        rnd = $random(seed) & 32'h000F_FFFF;
        enc_pos <= rnd;
        wr(4'h4, 0);
        note("ref_value", -rnd);
        note("act_pos", 0);
        post();
        wr(4'h3, 777);
        note("ref_value", 777);
        note("act_pos", rnd + 777);
        post();
        wr(4'h0, 1);
        note("dir_rev", 1);
        note("ref_value", 0);
        note("act_pos", -rnd);
        post();
        motor_pwr_ok <= 1'b0;
        repeat (5) @(posedge sys_clk);
        note("act_pos", -rnd);
        post();
        close_out();
    end
endmodule

// >>> verilog/prm_consts.svh
// Constants of the positioning range mapper: defaults, margins, scaling bounds.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH

// Factory default values (steps, standard scaling)
`define PRM_DEF_MAP_END 32'sd102400
`define PRM_DEF_LO_LIM 32'sd1200
`define PRM_DEF_HI_LIM 32'sd101200
`define PRM_DEF_ACT_POS 32'sd51200
`define PRM_DEF_REF_VAL 32'sd0
// Standard scaling factor
`define PRM_DEF_FACTOR 14'd400
`define PRM_FACTOR_MIN 14'd1
`define PRM_FACTOR_MAX 14'd10000
// Steps per output shaft rotation at standard scaling
`define PRM_STEPS_PER_REV 32'sd400
// Rotations below the mapping end for each limit
`define PRM_LO_MARGIN_REV 32'sd253
`define PRM_HI_MARGIN_REV 32'sd3
// Encoder span and usable span in rotations
`define PRM_ENC_REV 32'sd256
`define PRM_USE_REV 32'sd250
// Window around actual position for map-end bounds (standard steps)
`define PRM_MAP_MIN_OFS 32'sd1200
`define PRM_MAP_MAX_OFS 32'sd101200
// Degrees per step, in tenths, at standard scaling
`define PRM_DEG_TENTHS_PER_STEP 8'd9

`endif

// >>> verilog/prm_mapper.sv
// Positioning range mapper: upper mapping end, limits, target check, referencing.
// Assumes a master that issues one write strobe at a time and waits for busy low.
//
// How it works
// - Reject targets in margins; flag bad target
// - Defaults: map end 102400, limits 1200/101200
// - Default actual position is 51200
// - Accepted map end recomputes both limits
// - Limits are map end minus 253/3 rotations
// - Accept map end only if position inside new limits, within one step
// - Map end bounds: position plus scaled offsets
// - Bounds rounded to nearest integer
// - One rotation is 400*den/num steps
// - Standard scaling: one step is 0.9 degrees
// - Written actual position derives referencing value
// - Encoder spans 256 rotations, 250 usable
// - Motor supply loss leaves position intact
// - Direction setting selects counting sense
// - Limits may be narrowed after recompute
// - Scaling factors limited to 1..10000
`include "prm_consts.svh"

module prm_mapper
    import prm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic signed [31:0] enc_pos, // Physical encoder steps
    input wire logic motor_pwr_ok, // Motor supply present
    input wire logic dir_wr, // Direction write strobe
    input wire logic dir_val, // 1 = reversed counting sense
    input wire logic num_wr,
    input wire prm_pkg::prm_fac_t num_val,
    input wire logic den_wr,
    input wire prm_pkg::prm_fac_t den_val,
    input wire logic ref_wr,
    input wire logic signed [31:0] ref_val,
    input wire logic act_wr,
    input wire logic signed [31:0] act_val,
    input wire logic map_wr,
    input wire logic signed [31:0] map_val,
    input wire logic lo_wr,
    input wire logic signed [31:0] lo_val,
    input wire logic hi_wr,
    input wire logic signed [31:0] hi_val,
    input wire logic tgt_wr,
    input wire logic signed [31:0] tgt_val,
    output logic busy,
    output logic param_err,
    output logic tgt_ok,
    output logic tgt_err,
    output logic dir_rev,
    output prm_pkg::prm_fac_t numerator,
    output prm_pkg::prm_fac_t denominator,
    output logic signed [31:0] ref_value,
    output logic signed [31:0] act_pos,
    output logic signed [31:0] map_end,
    output logic signed [31:0] lo_limit,
    output logic signed [31:0] hi_limit
);
    import prm_pkg::*;

    prm_state_e state_r; // Map-end acceptance sequencer
    logic [1:0] step_r; // Which scaled product is in flight
    logic signed [31:0] map_cand_r; // Candidate map end being checked
    logic signed [31:0] lo_ofs_r; // Scaled 253-rotation offset
    logic signed [31:0] hi_ofs_r; // Scaled 3-rotation offset
    logic signed [31:0] min_ofs_r; // Scaled lower bound offset
    logic signed [31:0] max_ofs_r; // Scaled upper bound offset
    logic sc_start; // Divider kick
    logic signed [31:0] sc_value; // Divider operand
    logic sc_busy;
    logic sc_done;
    logic signed [31:0] sc_result;
    logic signed [31:0] pos_now; // Live actual position
    logic signed [31:0] map_lo_nxt; // Limits that would follow the candidate
    logic signed [31:0] map_hi_nxt;

    // Inside-range test with a one-step tolerance, used once in the map-end check
    function automatic logic in_window(input logic signed [31:0] p,
                                       input logic signed [31:0] lo,
                                       input logic signed [31:0] hi);
        in_window = (p >= lo - 32'sd1) && (p <= hi + 32'sd1);
    endfunction

    // Factor bound test, used for both scaling factors
    function automatic logic fac_ok(input prm_fac_t f);
        fac_ok = (f >= `PRM_FACTOR_MIN) && (f <= `PRM_FACTOR_MAX);
    endfunction

    // Actual position: sign by direction, shifted by referencing value.
    // The encoder is absolute, so no motor-supply term enters here.
    always_comb begin
        pos_now = (dir_rev ? -enc_pos : enc_pos) + ref_value;
        map_lo_nxt = map_cand_r - lo_ofs_r;
        map_hi_nxt = map_cand_r - hi_ofs_r;
    end

    // Operand for the divider; 400 steps per rotation scaled by den/num
    // At standard scaling 400 steps per turn give 0.9 degrees per step
    always_comb begin
        case (step_r)
            2'd0: sc_value = `PRM_STEPS_PER_REV * `PRM_LO_MARGIN_REV;
            2'd1: sc_value = `PRM_STEPS_PER_REV * `PRM_HI_MARGIN_REV;
            2'd2: sc_value = `PRM_MAP_MIN_OFS;
            default: sc_value = `PRM_MAP_MAX_OFS;
        endcase
    end

    assign sc_start = (state_r == PRM_CALC) && !sc_busy && !sc_done;

    // Rounded scaling of margins and bounds
    prm_scale u_scale (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(sc_start),
        .value(sc_value),
        .den(denominator),
        .num(numerator),
        .busy(sc_busy),
        .done(sc_done),
        .result(sc_result)
    );

    // Scaling factors and direction; out-of-range factors refused
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            numerator <= `PRM_DEF_FACTOR;
            denominator <= `PRM_DEF_FACTOR;
            dir_rev <= 1'b0;
        end else if (state_r == PRM_IDLE) begin
            if (dir_wr) begin
                dir_rev <= dir_val;
            end
            if (num_wr && fac_ok(num_val)) begin
                numerator <= num_val;
            end
            if (den_wr && fac_ok(den_val)) begin
                denominator <= den_val;
            end
        end
    end

    // Referencing value: direct, or derived from a written actual position
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_value <= `PRM_DEF_REF_VAL;
        end else if (state_r == PRM_IDLE) begin
            if (dir_wr) begin
                ref_value <= `PRM_DEF_REF_VAL;
            end else if (act_wr) begin
                ref_value <= act_val - (dir_rev ? -enc_pos : enc_pos);
            end else if (ref_wr) begin
                ref_value <= ref_val;
            end
        end
    end

    // Registered actual position output
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_pos <= `PRM_DEF_ACT_POS;
        end else begin
            act_pos <= pos_now;
        end
    end

    // Sequencer: scale four offsets, check, then commit map end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= PRM_IDLE;
            step_r <= 2'd0;
            map_cand_r <= `PRM_DEF_MAP_END;
            // Standard-scaling offsets, so narrowing works before any recompute
            lo_ofs_r <= `PRM_MAP_MAX_OFS;
            hi_ofs_r <= `PRM_MAP_MIN_OFS;
            min_ofs_r <= `PRM_MAP_MIN_OFS;
            max_ofs_r <= `PRM_MAP_MAX_OFS;
        end else begin
            case (state_r)
                PRM_IDLE: begin
                    step_r <= 2'd0;
                    if (map_wr) begin
                        map_cand_r <= map_val;
                        state_r <= PRM_CALC;
                    end else if (num_wr || den_wr || dir_wr) begin
                        // Scaling or direction change re-derives the default map
                        map_cand_r <= `PRM_DEF_MAP_END;
                        state_r <= PRM_CALC;
                    end
                end
                PRM_CALC: begin
                    if (sc_done) begin
                        case (step_r)
                            2'd0: lo_ofs_r <= sc_result;
                            2'd1: hi_ofs_r <= sc_result;
                            2'd2: min_ofs_r <= sc_result;
                            default: max_ofs_r <= sc_result;
                        endcase
                        step_r <= step_r + 2'd1;
                        if (step_r == 2'd3) begin
                            state_r <= PRM_CHECK;
                        end
                    end
                end
                PRM_CHECK: begin
                    state_r <= PRM_DONE;
                end
                PRM_DONE: begin
                    state_r <= PRM_IDLE;
                end
                default: begin
                    state_r <= PRM_IDLE;
                end
            endcase
        end
    end

    // Map end and limits; commit only when the candidate passes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            map_end <= `PRM_DEF_MAP_END;
            lo_limit <= `PRM_DEF_LO_LIM;
            hi_limit <= `PRM_DEF_HI_LIM;
            param_err <= 1'b0;
        end else begin
            if (state_r == PRM_CHECK) begin
                // Bounds from live position and rounded offsets
                if (map_cand_r >= pos_now + min_ofs_r && map_cand_r <= pos_now + max_ofs_r
                    && in_window(pos_now, map_lo_nxt, map_hi_nxt)) begin
                    map_end <= map_cand_r;
                    lo_limit <= map_lo_nxt;
                    hi_limit <= map_hi_nxt;
                    param_err <= 1'b0;
                end else begin
                    param_err <= 1'b1;
                end
            end else if (state_r == PRM_IDLE) begin
                // Limits may only move inside the derived range, never past each other
                if (lo_wr) begin
                    if (lo_val >= map_end - lo_ofs_r && lo_val <= hi_limit) begin
                        lo_limit <= lo_val;
                    end else begin
                        param_err <= 1'b1;
                    end
                end
                if (hi_wr) begin
                    if (hi_val <= map_end - hi_ofs_r && hi_val >= lo_limit) begin
                        hi_limit <= hi_val;
                    end else begin
                        param_err <= 1'b1;
                    end
                end
            end
        end
    end

    // Target check against the margin-free limits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgt_ok <= 1'b0;
            tgt_err <= 1'b0;
        end else begin
            tgt_ok <= 1'b0;
            tgt_err <= 1'b0;
            if (tgt_wr) begin
                if (tgt_val >= lo_limit && tgt_val <= hi_limit) begin
                    tgt_ok <= 1'b1;
                end else begin
                    tgt_err <= 1'b1;
                end
            end
        end
    end

    // Busy covers any map-end sequence; writes meanwhile are dropped, except target writes, which are still checked
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r != PRM_IDLE) || map_wr || num_wr || den_wr || dir_wr;
        end
    end

    // motor_pwr_ok is accepted but deliberately unused: position stays valid
    logic unused_pwr;
    assign unused_pwr = motor_pwr_ok;
endmodule

// >>> verilog/prm_pkg.sv
// Types shared by the positioning range mapper files.
// Assumes nothing beyond a SystemVerilog compiler.
package prm_pkg;
    typedef logic signed [31:0] prm_pos_t; // Signed positions, wide enough for 1e6+
    typedef logic [13:0] prm_fac_t; // Scaling factor 1..10000
    typedef enum logic [3:0] {
        PRM_IDLE = 4'h1,
        PRM_CALC = 4'h2,
        PRM_CHECK = 4'h4,
        PRM_DONE = 4'h8
    } prm_state_e;
endpackage

// >>> verilog/prm_scale.sv
// Scaled step count: round(value * den / num), sequential restoring divide.
// Assumes start is pulsed only while busy is low; operands held by caller.
`include "prm_consts.svh"

module prm_scale
    import prm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic signed [31:0] value,
    input wire prm_pkg::prm_fac_t den,
    input wire prm_pkg::prm_fac_t num,
    output logic busy,
    output logic done,
    output logic signed [31:0] result
);
    logic [47:0] rem_r; // Running remainder / dividend
    logic [47:0] quo_r; // Quotient bits
    logic [5:0] cnt_r; // Bits left
    logic neg_r; // Sign of value
    logic [47:0] dvd; // Doubled magnitude product plus num, for rounding
    logic [48:0] trial; // Trial subtraction

    // Round-to-nearest: floor((2*|v|*den + num) / (2*num))
    always_comb begin
        dvd = 48'((value < 0 ? -value : value)) * 48'(den);
        dvd = (dvd << 1) + 48'(num);
        trial = {rem_r[47:0], quo_r[47]} - {34'h0, num, 1'b0};
    end

    // Shift-subtract divider, one quotient bit per clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_r <= 48'h0;
            quo_r <= 48'h0;
            cnt_r <= 6'h0;
            neg_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            result <= 32'sh0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_r <= 48'h0;
                quo_r <= dvd;
                neg_r <= value < 0;
                cnt_r <= 6'd48;
                busy <= 1'b1;
            end else if (busy) begin
                if (!trial[48]) begin
                    rem_r <= trial[47:0];
                    quo_r <= {quo_r[46:0], 1'b1};
                end else begin
                    rem_r <= {rem_r[46:0], quo_r[47]};
                    quo_r <= {quo_r[46:0], 1'b0};
                end
                cnt_r <= cnt_r - 6'd1;
                if (cnt_r == 6'd1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // Final quotient bit folded in here
                    result <= neg_r ? -32'({quo_r[46:0], ~trial[48]})
                                    : 32'({quo_r[46:0], ~trial[48]});
                end
            end
        end
    end
endmodule
